// File: shared/wdsr_params.svh
// constants for the watchdog, sleep/wake and reset-status block
`ifndef WDSR_PARAMS_SVH
`define WDSR_PARAMS_SVH
// register byte offsets
`define WDSR_OFF_OPTION 8'h00
`define WDSR_OFF_STATUS 8'h04
`define WDSR_OFF_CMD 8'h08
`define WDSR_OFF_CONFIG 8'h0C
`define WDSR_OFF_PROG 8'h10
// option fields
`define WDSR_OPT_WAKE_N 7
`define WDSR_OPT_PS_ASSIGN 3
`define WDSR_OPT_PS_LO 0
// status fields
`define WDSR_ST_WAKE 7
`define WDSR_ST_TO 4
`define WDSR_ST_PWRDN 3
// command strobes (write one)
`define WDSR_CMD_CLEAR 0
`define WDSR_CMD_SLEEP 1
`define WDSR_CMD_PORTRD 2
// configuration fuses
`define WDSR_CFG_WD_EN 0
`define WDSR_CFG_MCLRE 1
`define WDSR_CFG_XTAL 2
`define WDSR_CFG_CP_N 3
// reset values
`define WDSR_OPTION_RST 8'hFF
`define WDSR_CONFIG_RST 4'hF
// timing
`define WDSR_CLK_MHZ 125
`define WDSR_WDT_MS 18
`define WDSR_HOLD_MS 18
`define WDSR_WDT_CYC (`WDSR_WDT_MS * 1000 * `WDSR_CLK_MHZ)
`define WDSR_HOLD_CYC (`WDSR_HOLD_MS * 1000 * `WDSR_CLK_MHZ)
// serial programming
`define WDSR_CMD_BITS 6
`define WDSR_DATA_BITS 14
`define WDSR_OPEN_ROWS 64
`define WDSR_PCMD_LOAD 6'h02
`define WDSR_PCMD_READ 6'h04
`define WDSR_PCMD_INC 6'h06
`endif

// File: shared/wdsr_pkg.sv
// types for the watchdog, sleep/wake and reset-status block
package wdsr_pkg;
  typedef enum logic [1:0] {
    WS_RUN = 2'b00,
    WS_SLEEP = 2'b01
  } wdsr_pwr_t;
  typedef enum logic [1:0] {
    SS_CMD = 2'b00,
    SS_LOAD = 2'b01,
    SS_READ = 2'b10
  } wdsr_ser_t;
endpackage

// File: core/wdsr_core.sv
// watchdog, sleep/wake control, reset-cause flags and serial programming port
`timescale 1ns/1ps
`include "wdsr_params.svh"
// Notes on behaviour
// - with no prescaler the watchdog expires after 18 ms
// - option register can assign prescaler to watchdog, up to 1:128
// - clear-watchdog clears counter and assigned prescaler, avoiding time-out
// - sleep clears counter and assigned prescaler for longest sleep
// - option holds wake, pull-up, timer, prescaler bits; all ones on every reset
// - flag codes after reset identify the reset cause
// - flags hold until a listed event; master-clear pulse awake changes none
// - events set and clear the three flags per the event table
// - time-out and sleep act whatever the flags hold
// - sleep clears running watchdog, sets timeout, clears powerdown, stops oscillator
// - pins hold their driven state during sleep
// - watchdog reset is internal only, never drives master-clear pin
// - wake on master-clear, watchdog, or enabled pin change; full reset
// - pin change compares with last port read snapshot
// - waking clears the watchdog whatever the source
// - readout only when unprotected, except first 64 locations
// - four id words reachable only in program/verify mode
// - 6-bit command then 14 data bits loaded or returned
// - watchdog enable fuse at zero disables watchdog entirely
// - in crystal modes watchdog time-out starts the reset timer
module wdsr_core import wdsr_pkg::*; #(
  parameter int WDT_CYC = `WDSR_WDT_CYC,
  parameter int HOLD_CYC = `WDSR_HOLD_CYC,
  parameter int CNT_W = 22
) (
  input wire logic clk, // 125 MHz
  input wire logic rst, // power-up reset
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  input wire logic master_clear_n, // master-clear pin level
  input wire logic programming_high_level, // pin at programming voltage
  input wire logic port_pin_zero, // pin 0 in
  input wire logic port_pin_one, // pin 1 in
  input wire logic port_pin_three, // pin 3 in
  input wire logic [9:0] pm_addr, // readout address
  output logic pin0_out, // serial data out
  output logic pin0_oe, // serial data enable
  output logic dev_reset, // internal reset pulse
  output logic cpu_hold, // reset timer running
  output logic osc_off, // main oscillator stopped
  output logic io_hold, // pins frozen
  output logic prog_mode, // program/verify mode
  output logic pm_read_ok // readout allowed
);
  // ==========================================================
  // elaboration checks
  if (WDT_CYC < 2 || WDT_CYC >= (1 << CNT_W)) begin : g_chk_wdt
    $error("WDT_CYC out of range");
  end
  if (HOLD_CYC < 2 || HOLD_CYC >= (1 << CNT_W)) begin : g_chk_hold
    $error("HOLD_CYC out of range");
  end

  // ==========================================================
  // bus slave
  logic wr_q;
  logic [7:0] wa_q;
  logic [7:0] option_q;
  logic [3:0] config_q;
  logic wake_q, to_q, pwrdn_q;
  wdsr_pwr_t pwr_q;
  logic [1:0] id_ptr_q;
  logic [13:0] id_q [4];
  wdsr_ser_t ser_q;
  logic [13:0] sh_q;
  logic [4:0] bit_q;
  logic [5:0] cmd_sh_q;
  logic acc;
  logic [31:0] rd_val;
  assign acc = hsel & hready & htrans[1];
  // read mux for the address phase
  always_comb begin
    rd_val = 32'h0;
    unique case (haddr[7:0])
      `WDSR_OFF_OPTION: rd_val[7:0] = option_q;
      `WDSR_OFF_STATUS: begin
        rd_val[`WDSR_ST_WAKE] = wake_q;
        rd_val[`WDSR_ST_TO] = to_q;
        rd_val[`WDSR_ST_PWRDN] = pwrdn_q;
      end
      `WDSR_OFF_CONFIG: rd_val[3:0] = config_q;
      `WDSR_OFF_PROG: rd_val[15:0] = {prog_mode, ser_q, id_ptr_q, 11'h0};
      default: rd_val = 32'h0;
    endcase
  end
  // zero wait states: read data is registered at the address phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_q <= acc & hwrite;
      if (acc) begin
        wa_q <= haddr[7:0];
      end
      if (acc & ~hwrite) begin
        hrdata <= rd_val;
      end
    end
  end
  logic w_opt, w_cfg, w_cmd;
  assign w_opt = wr_q & (wa_q == `WDSR_OFF_OPTION);
  assign w_cfg = wr_q & (wa_q == `WDSR_OFF_CONFIG);
  assign w_cmd = wr_q & (wa_q == `WDSR_OFF_CMD);

  // ==========================================================
  // instruction strobes; the core is stopped while asleep
  logic i_clr, i_sleep, i_prd, awake;
  assign awake = (pwr_q == WS_RUN) & ~cpu_hold;
  assign i_clr = w_cmd & awake & hwdata[`WDSR_CMD_CLEAR];
  assign i_sleep = w_cmd & awake & hwdata[`WDSR_CMD_SLEEP];
  assign i_prd = w_cmd & awake & hwdata[`WDSR_CMD_PORTRD];

  // ==========================================================
  // watchdog counter and prescaler
  logic [CNT_W-1:0] wdt_q;
  logic [6:0] ps_q, ps_mask;
  logic wdt_en, base_tick, ps_on, wdt_to, wdt_clr;
  logic ev_xclr, ev_pin, ev_reset;
  assign wdt_en = config_q[`WDSR_CFG_WD_EN];
  assign ps_on = option_q[`WDSR_OPT_PS_ASSIGN];
  assign ps_mask = 7'(({7'h00, 1'b1} << option_q[2:0]) - 8'h01);
  assign base_tick = (wdt_q == CNT_W'(WDT_CYC - 1));
  // expiry ignores the flags
  assign wdt_to = wdt_en & base_tick & (~ps_on | ((ps_q & ps_mask) == ps_mask));
  // clear on instruction, sleep, and any reset or wake
  assign wdt_clr = i_clr | i_sleep | ev_reset;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_q <= '0;
    end else if (wdt_clr | ~wdt_en | base_tick) begin
      wdt_q <= '0;
    end else begin
      wdt_q <= wdt_q + CNT_W'(1);
    end
  end
  // prescaler only steps on base ticks when assigned; cleared with the counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ps_q <= 7'h00;
    end else if ((wdt_clr & ps_on) | wdt_to) begin
      ps_q <= 7'h00;
    end else if (ps_on & base_tick) begin
      ps_q <= ps_q + 7'h01;
    end
  end

  // ==========================================================
  // wake and reset sources
  logic xclr_n_q, hv_q;
  logic [2:0] snap_q;
  logic [2:0] pins;
  assign pins = {port_pin_three, port_pin_one, port_pin_zero};
  assign ev_xclr = config_q[`WDSR_CFG_MCLRE] & xclr_n_q & ~master_clear_n & ~prog_mode;
  // pins 0, 1, 3 against last read snapshot
  assign ev_pin = (pwr_q == WS_SLEEP) & ~option_q[`WDSR_OPT_WAKE_N] & (pins != snap_q);
  assign ev_reset = wdt_to | ev_xclr | ev_pin;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xclr_n_q <= 1'b1;
      hv_q <= 1'b0;
      snap_q <= 3'b000;
    end else begin
      xclr_n_q <= master_clear_n;
      hv_q <= programming_high_level;
      if (i_prd) begin
        snap_q <= pins;
      end
    end
  end

  // ==========================================================
  // power state: sleep stops the oscillator and freezes pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_q <= WS_RUN;
      osc_off <= 1'b0;
      io_hold <= 1'b0;
    end else begin
      unique case (pwr_q)
        WS_RUN: begin
          if (i_sleep & ~ev_reset) begin
            pwr_q <= WS_SLEEP;
            osc_off <= 1'b1;
            io_hold <= 1'b1;
          end
        end
        WS_SLEEP: begin
          if (ev_reset) begin
            pwr_q <= WS_RUN;
            osc_off <= 1'b0;
            io_hold <= 1'b0;
          end
        end
        // unused codes fall back to running
        default: begin
          pwr_q <= WS_RUN;
          osc_off <= 1'b0;
          io_hold <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // internal reset pulse and device reset timer; the master-clear
  // pin is input only, so a watchdog reset never pulls it low
  logic [CNT_W-1:0] hold_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dev_reset <= 1'b0;
      hold_q <= '0;
      cpu_hold <= 1'b0;
    end else begin
      dev_reset <= ev_reset;
      if (wdt_to & config_q[`WDSR_CFG_XTAL]) begin
        hold_q <= CNT_W'(HOLD_CYC - 1);
        cpu_hold <= 1'b1;
      end else if (hold_q != '0) begin
        hold_q <= hold_q - CNT_W'(1);
      end else begin
        cpu_hold <= 1'b0;
      end
    end
  end

  // ==========================================================
  // reset-cause flags; hardware events win over instructions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_q <= 1'b0;
      to_q <= 1'b1;
      pwrdn_q <= 1'b1;
    end else if (wdt_to) begin
      wake_q <= 1'b0;
      to_q <= 1'b0;
    end else if (ev_pin) begin
      wake_q <= 1'b1;
      to_q <= 1'b1;
      pwrdn_q <= 1'b0;
    end else if (ev_xclr & (pwr_q == WS_SLEEP)) begin
      wake_q <= 1'b0;
      to_q <= 1'b1;
    end else if (i_sleep) begin
      to_q <= 1'b1;
      pwrdn_q <= 1'b0;
    end else if (i_clr) begin
      to_q <= 1'b1;
      pwrdn_q <= 1'b1;
    end
  end
  // an awake master-clear pulse falls through above with no change

  // ==========================================================
  // option and configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      option_q <= `WDSR_OPTION_RST;
    end else if (ev_reset) begin
      option_q <= `WDSR_OPTION_RST;
    end else if (w_opt) begin
      option_q <= hwdata[7:0];
    end
  end
  // fuses model one-time bits; writable here for bring-up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_q <= `WDSR_CONFIG_RST;
    end else if (w_cfg) begin
      config_q <= hwdata[3:0];
    end
  end
  // readout gate for verification
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pm_read_ok <= 1'b0;
    end else begin
      pm_read_ok <= config_q[`WDSR_CFG_CP_N] | (pm_addr < 10'(`WDSR_OPEN_ROWS));
    end
  end

  // ==========================================================
  // program/verify entry on the rise to programming level
  logic clk1_q, sclk_rise;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_mode <= 1'b0;
    end else if (~hv_q & programming_high_level & ~port_pin_one & ~port_pin_zero) begin
      prog_mode <= 1'b1;
    end else if (~programming_high_level) begin
      prog_mode <= 1'b0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk1_q <= 1'b0;
    end else begin
      clk1_q <= port_pin_one;
    end
  end
  assign sclk_rise = prog_mode & port_pin_one & ~clk1_q;

  // ==========================================================
  // serial framing: 6 command bits then 14 data bits, lsb first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ser_q <= SS_CMD;
      sh_q <= 14'h0000;
      cmd_sh_q <= 6'h00;
      bit_q <= 5'd0;
      id_ptr_q <= 2'd0;
      pin0_out <= 1'b0;
      pin0_oe <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        id_q[i] <= 14'h0000;
      end
    end else if (~prog_mode) begin
      ser_q <= SS_CMD;
      bit_q <= 5'd0;
      pin0_oe <= 1'b0;
    end else if (sclk_rise) begin
      unique case (ser_q)
        SS_CMD: begin
          cmd_sh_q <= {port_pin_zero, cmd_sh_q[5:1]};
          bit_q <= bit_q + 5'd1;
          if (bit_q == 5'(`WDSR_CMD_BITS - 1)) begin
            bit_q <= 5'd0;
            unique case ({port_pin_zero, cmd_sh_q[5:1]})
              `WDSR_PCMD_LOAD: ser_q <= SS_LOAD;
              `WDSR_PCMD_READ: begin
                ser_q <= SS_READ;
                sh_q <= {1'b0, id_q[id_ptr_q][13:1]};
                pin0_out <= id_q[id_ptr_q][0];
                pin0_oe <= 1'b1;
              end
              `WDSR_PCMD_INC: id_ptr_q <= id_ptr_q + 2'd1;
              default: ser_q <= SS_CMD;
            endcase
          end
        end
        SS_LOAD: begin
          sh_q <= {port_pin_zero, sh_q[13:1]};
          bit_q <= bit_q + 5'd1;
          if (bit_q == 5'(`WDSR_DATA_BITS - 1)) begin
            id_q[id_ptr_q] <= {port_pin_zero, sh_q[13:1]};
            bit_q <= 5'd0;
            ser_q <= SS_CMD;
          end
        end
        SS_READ: begin
          pin0_out <= sh_q[0];
          sh_q <= {1'b0, sh_q[13:1]};
          bit_q <= bit_q + 5'd1;
          if (bit_q == 5'(`WDSR_DATA_BITS - 1)) begin
            pin0_oe <= 1'b0;
            bit_q <= 5'd0;
            ser_q <= SS_CMD;
          end
        end
        default: ser_q <= SS_CMD;
      endcase
    end
  end

  // ==========================================================
  // assertions
  a_to_clears_flag: assert property (@(posedge clk) disable iff (rst)
    wdt_to |=> !to_q && !wake_q) else $error("timeout flag not cleared");
  a_sleep_flags: assert property (@(posedge clk) disable iff (rst)
    i_sleep && !ev_reset |=> to_q && !pwrdn_q && osc_off) else $error("sleep flags");
  a_clr_flags: assert property (@(posedge clk) disable iff (rst)
    i_clr && !i_sleep && !ev_reset |=> to_q && pwrdn_q) else $error("clear flags");
  a_clr_counter: assert property (@(posedge clk) disable iff (rst)
    (i_clr || i_sleep) |=> wdt_q == '0 ##1 wdt_q == CNT_W'(1) || !wdt_en)
    else $error("counter not cleared");
  a_fuse_off: assert property (@(posedge clk) disable iff (rst)
    !wdt_en |-> !wdt_to) else $error("disabled watchdog expired");
  a_pin_wake: assert property (@(posedge clk) disable iff (rst)
    ev_pin && !wdt_to |=> wake_q && to_q && !pwrdn_q && dev_reset && !io_hold)
    else $error("pin wake");
  a_option_rst: assert property (@(posedge clk) disable iff (rst)
    ev_reset |=> option_q == `WDSR_OPTION_RST) else $error("option reset");
  a_xclr_awake: assert property (@(posedge clk) disable iff (rst)
    ev_xclr && pwr_q == WS_RUN && !wdt_to && !i_sleep && !i_clr
    |=> $stable(to_q) && $stable(pwrdn_q) && $stable(wake_q))
    else $error("master-clear changed flags");
  a_hold_start: assert property (@(posedge clk) disable iff (rst)
    wdt_to && config_q[`WDSR_CFG_XTAL] |=> cpu_hold [*8]) else $error("reset hold");
  a_no_ps_period: assert property (@(posedge clk) disable iff (rst)
    wdt_to && !ps_on |-> wdt_q == CNT_W'(WDT_CYC - 1)) else $error("period");
  a_read_gate: assert property (@(posedge clk) disable iff (rst)
    pm_addr < 10'(`WDSR_OPEN_ROWS) |=> pm_read_ok) else $error("open rows");
  c_wdt_wake: cover property (@(posedge clk) disable iff (rst)
    pwr_q == WS_SLEEP && wdt_to);
  c_pin_wake: cover property (@(posedge clk) disable iff (rst) ev_pin);
  c_prog_read: cover property (@(posedge clk) disable iff (rst)
    ser_q == SS_READ && pin0_oe);
endmodule

// File: tb/tb_top.sv
// self-checking testbench for the watchdog, sleep/wake and reset-status block
`timescale 1ns/1ps
`include "wdsr_params.svh"
module tb_top;
  // ==========================================
  // signals
  localparam logic [31:0] A_OPT = {24'h00, `WDSR_OFF_OPTION};
  localparam logic [31:0] A_ST = {24'h00, `WDSR_OFF_STATUS};
  localparam logic [31:0] A_CMD = {24'h00, `WDSR_OFF_CMD};
  localparam logic [31:0] A_CFG = {24'h00, `WDSR_OFF_CONFIG};
  localparam logic [31:0] A_PRG = {24'h00, `WDSR_OFF_PROG};
  logic clk, rst, hsel, hwrite, mcn, phl, p0_drv, p1, p3;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [9:0] pm_addr;
  logic hreadyout, hresp, pin0_out, pin0_oe, dev_reset, cpu_hold;
  logic osc_off, io_hold, prog_mode, pm_read_ok;
  wire p0_w;
  int err_count, n_tests, n_rst, n;
  // pin 0 is shared: the device wins while it drives
  assign p0_w = pin0_oe ? pin0_out : p0_drv;
  // short counts keep the run brief; expectations scale from these
  wdsr_core #(.WDT_CYC(20), .HOLD_CYC(30)) i_wdsr_core (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .master_clear_n(mcn), .programming_high_level(phl),
    .port_pin_zero(p0_w), .port_pin_one(p1), .port_pin_three(p3),
    .pm_addr(pm_addr), .pin0_out(pin0_out), .pin0_oe(pin0_oe),
    .dev_reset(dev_reset), .cpu_hold(cpu_hold), .osc_off(osc_off),
    .io_hold(io_hold), .prog_mode(prog_mode), .pm_read_ok(pm_read_ok));
  // ==========================================
  // clock and pulse counter
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (dev_reset === 1'b1) n_rst++;
  // ==========================================
  // shared tasks
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask
  // one single-word transfer; address held until hready, then data phase
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] mk, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd & mk, e, "register read");
  endtask
  // counts cycles until the internal reset pulse, at most mx
  task automatic wait_rst(input int mx);
    n = 0;
    while (n < mx) begin
      @(posedge clk);
      #1;
      n++;
      if (dev_reset === 1'b1) break;
    end
  endtask
  task automatic rst_dut();
    @(posedge clk);
    rst <= 1'b1;
    tick(12);
    rst <= 1'b0;
  endtask
  task automatic xclr_pulse();
    @(posedge clk);
    mcn <= 1'b0;
    tick(3);
    mcn <= 1'b1;
    tick(3);
  endtask
  // levels held three cycles each so the sampler sees every edge
  task automatic ser_bit(input logic b);
    @(posedge clk);
    p0_drv <= b;
    p1 <= 1'b0;
    tick(3);
    p1 <= 1'b1;
    tick(3);
  endtask
  task automatic ser_cmd(input logic [5:0] c);
    for (int i = 0; i < 6; i++) ser_bit(c[i]);
  endtask
  task automatic ser_dat(input logic [13:0] v);
    for (int i = 0; i < 14; i++) ser_bit(v[i]);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    rdc(A_OPT, 32'hFF, 32'hFF);
    rdc(A_ST, 32'h98, 32'h18);
    rdc(A_CFG, 32'hF, 32'hF);
    rdc(32'h40, 32'hFFFFFFFF, 32'h0);
    chk({hreadyout, hresp}, 2'b10, "bus not ready or not okay");
  endtask
  // regular clears keep the counter from ever expiring
  task automatic t_clear();
    int c;
    rst_dut();
    wr(A_OPT, 32'h80);
    c = n_rst;
    repeat (6) begin
      wr(A_CMD, 32'h1);
      tick(10);
    end
    chk(n_rst - c, 0, "reset despite clears");
    rdc(A_ST, 32'h98, 32'h18);
  endtask
  // time-out with and without prescaler, then the crystal-mode hold
  task automatic t_wdt();
    logic [31:0] opt[4] = '{32'h80, 32'h88, 32'h89, 32'h8B};
    int per[4] = '{20, 20, 40, 160};
    rst_dut();
    for (int i = 0; i < 4; i++) begin
      wr(A_OPT, opt[i]);
      wr(A_CMD, 32'h1);
      wait_rst(400);
      chk(n >= per[i] - 1 && n <= per[i] + 3, 1, "time-out period");
      chk(cpu_hold, 1, "hold missing");
      rdc(A_ST, 32'h98, 32'h08);
      rdc(A_OPT, 32'hFF, 32'hFF);
      tick(35);
      chk(cpu_hold, 0, "hold too long");
    end
  endtask
  // sleep restarts the counter; the watchdog then wakes the device
  task automatic t_sleep();
    rst_dut();
    wr(A_OPT, 32'h80);
    wr(A_CMD, 32'h1);
    tick(12);
    wr(A_CMD, 32'h2);
    rdc(A_ST, 32'h98, 32'h10);
    chk({osc_off, io_hold}, 2'b11, "not asleep");
    wait_rst(60);
    chk(n >= 13 && n <= 22, 1, "sleep period");
    chk(osc_off, 0, "still asleep");
    rdc(A_ST, 32'h98, 32'h00);
  endtask
  // master-clear wake, then a pulse while awake leaves the flags
  task automatic t_xclr();
    int c;
    rst_dut();
    wr(A_CFG, 32'hE);
    wr(A_CMD, 32'h2);
    tick(60);
    chk(osc_off, 1, "woke with watchdog off");
    xclr_pulse();
    chk(osc_off, 0, "no wake");
    rdc(A_ST, 32'h98, 32'h10);
    wr(A_OPT, 32'h0);
    c = n_rst;
    xclr_pulse();
    chk(n_rst - c, 1, "no reset pulse");
    rdc(A_ST, 32'h98, 32'h10);
    rdc(A_OPT, 32'hFF, 32'hFF);
  endtask
  // pin change against the last snapshot wakes the device
  task automatic t_pin();
    rst_dut();
    wr(A_CFG, 32'hE);
    wr(A_OPT, 32'h08);
    wr(A_CMD, 32'h4);
    wr(A_CMD, 32'h2);
    tick(10);
    chk(osc_off, 1, "woke with no change");
    @(posedge clk);
    p3 <= ~p3;
    wait_rst(10);
    chk(n < 10, 1, "no pin wake");
    rdc(A_ST, 32'h98, 32'h90);
  endtask
  task automatic t_pm();
    rst_dut();
    wr(A_CFG, 32'h6);
    pm_addr <= 10'd63;
    tick(2);
    chk(pm_read_ok, 1, "open row refused");
    pm_addr <= 10'd64;
    tick(2);
    chk(pm_read_ok, 0, "protected row read");
    wr(A_CFG, 32'hF);
    tick(2);
    chk(pm_read_ok, 1, "unprotected refused");
  endtask
  // serial load of an id word, then read it back on pin 0
  task automatic t_prog();
    logic [13:0] v;
    rst_dut();
    wr(A_CFG, 32'hE);
    @(posedge clk);
    phl <= 1'b1;
    tick(3);
    chk(prog_mode, 1, "no program mode");
    rdc(A_PRG, 32'h8000, 32'h8000);
    ser_cmd(`WDSR_PCMD_LOAD);
    ser_dat(14'h0009);
    ser_cmd(`WDSR_PCMD_READ);
    for (int i = 0; i < 14; i++) begin
      if (i > 0) ser_bit(1'b0);
      chk(pin0_oe, 1, "pin 0 not driven");
      v[i] = p0_w;
    end
    ser_bit(1'b0);
    chk(pin0_oe, 0, "pin 0 still driven");
    chk(v, 14'h0009, "id word");
    // the increment command moves the id pointer to the second word
    ser_cmd(`WDSR_PCMD_INC);
    rdc(A_PRG, 32'h7800, 32'h0800);
    phl <= 1'b0;
    tick(3);
    chk(prog_mode, 0, "mode not left");
  endtask
  // ==========================================
  // main sequence and hang guard
  initial begin
    {rst, hsel, hwrite, phl, p0_drv, p1} = 6'b100000;
    {mcn, p3} = 2'b11;
    {haddr, hwdata, htrans, hsize, pm_addr} = {64'h0, 2'h0, 3'h2, 10'h0};
    err_count = 0;
    n_tests = 0;
    n_rst = 0;
    tick(12);
    rst <= 1'b0;
    t_reset();
    t_clear();
    t_wdt();
    t_sleep();
    t_xclr();
    t_pin();
    t_pm();
    t_prog();
    finish_test();
  end
  initial begin
    tick(20000);
    err_count++;
    $display("[ERR] %0t run did not complete", $time);
    finish_test();
  end
endmodule
